//--- iosi_pkg.sv
package iosi_pkg;

   // five-second transfer timer
   localparam int unsigned TIMER_SECONDS = 5;
   localparam longint unsigned CLK_HZ = 64'd250_000_000;
   localparam longint unsigned TIMER_CYCLES = TIMER_SECONDS * CLK_HZ;

   // selective clear codes (bits a,b,c as a 3-bit value, a is msb)
   localparam logic [2:0] CLR_TIME_XFER = 3'h1;
   localparam logic [2:0] CLR_PROG = 3'h0;
   localparam logic [2:0] CLR_CLEAR_IF = 3'h2;
   localparam logic [2:0] CLR_DATA_XFER = 3'h3;
   localparam logic [2:0] CLR_DEV_A = 3'h4;
   localparam logic [2:0] CLR_DEV_B = 3'h5;
   localparam logic [2:0] CLR_DEV_C = 3'h6;

   // interrupt status byte positions (status bit 8 + index)
   localparam int unsigned IST_DEV_A = 0;
   localparam int unsigned IST_DEV_B = 1;
   localparam int unsigned IST_DEV_C = 2;
   localparam int unsigned IST_DATA_XFER = 3;
   localparam int unsigned IST_CLEAR_IF = 4;
   localparam int unsigned IST_PROG = 5;
   localparam int unsigned IST_XFER_ERR = 6;
   localparam int unsigned IST_TIME_OUT = 7;

   localparam logic [7:0] IST_RESET = 8'h00;
   localparam logic [1:0] SEQ_COUNT_0 = 2'h0;
   localparam logic [1:0] SEQ_COUNT_3 = 2'h3;

   // control word strobe contents
   typedef struct packed {
      logic ctl_master_reset_bit;
      logic ctl_clear_all_bit;
      logic ctl_clear_sel_bit_a;
      logic ctl_clear_sel_bit_b;
      logic ctl_clear_sel_bit_c;
      logic ctl_data_int_bit;
      logic ctl_interrupt_enable_bit;
      logic ctl_timer_start_bit;
   } iosi_ctl_type;

   // jumper options
   typedef struct packed {
      logic opt_status11_request;
      logic opt_dev_int_a;
      logic opt_dev_int_b;
      logic opt_dev_int_c;
   } iosi_opt_type;

endpackage : iosi_pkg

//--- iosi_service_interrupt.sv
`timescale 1ns/1ps
// Operation
// - two-byte device end at count 3 zeroes low byte
// - second-byte device end: inhibit command, request service
// - forward device end only if more data
// - service requests only in channel programs
// - request low while any request flop set
// - acknowledge clears all four request flops
// - option lets status bit 11 set command request
// - eight interrupt sources, each own flop
// - latch channel transfer error interrupt
// - latch programmed and clear-interface interrupts
// - data interrupt on count 3 to 0 step
// - selective clear via decoder bits one-four
// - timer start bit runs five-second timer
// - start flop holds until written zero or reset
// - time-out sets status 15 and pending
// - three jumper-enabled device interrupts
// - inputs 8,9 leading edge, 10 trailing
// - pending whenever any source set
// - enable bit 14 gates request with pending
// - enable clears on zero, reset, poll accept
// - block new request while previous active
// - clear-all or master reset clears all sources
module iosi_service_interrupt #(
   parameter longint unsigned TIMER_COUNT = iosi_pkg::TIMER_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // control word strobe
   input wire logic ctl_strobe,
   input wire iosi_pkg::iosi_ctl_type ctl_word,
   input wire iosi_pkg::iosi_opt_type opt,
   // sequence and transfer state
   input wire logic program_mode,
   input wire logic [1:0] seq_count,
   input wire logic two_byte_xfer,
   input wire logic more_data,
   input wire logic cmd_done,
   input wire logic data_in_ready,
   input wire logic data_out_ready,
   input wire logic xfer_finished,
   // device pins (asynchronous)
   input wire logic device_end_pin,
   input wire logic clear_interface_pin,
   input wire logic [3:0] dev_status_pin,
   // channel and command function
   input wire logic service_request_ack,
   input wire logic channel_transfer_error,
   input wire logic programmed_int_req,
   input wire logic interrupt_poll_accept_n,
   input wire logic master_clear_n,
   input wire logic interrupt_active,
   // outputs
   output logic service_request_n,
   output logic device_end_to_channel,
   output logic device_command_inhibit,
   output logic zero_low_byte,
   output logic interrupt_pending,
   output logic interrupt_request,
   output logic [7:0] interrupt_status
);
   import iosi_pkg::*;

   // counter replaces the one-shot; its length follows the clock rate, so a new clock needs a new count
   localparam int TW = $clog2(TIMER_COUNT + 1);

   // device pins pass three flops; a change counts once stages two and three agree
   logic [5:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
   logic [5:0] nxt_sync1, nxt_sync2, nxt_sync3, nxt_pin;
   logic command_request_ff, transfer_request_ff, data_request_ff;
   logic end_of_transfer_request_ff;
   logic nxt_cmd_rq, nxt_xfer_rq, nxt_data_rq, nxt_eot_rq;
   logic dev_end_ff, nxt_dev_end, zero_ff, nxt_zero, fwd_end_ff, nxt_fwd_end;
   logic [7:0] src_ff, nxt_src;
   logic start_ff, nxt_start, ien_ff, nxt_ien, timed_out_ff, nxt_timed_out;
   logic [TW-1:0] timer_ff, nxt_timer;
   logic [1:0] seq_prev_ff, nxt_seq_prev;
   logic [7:0] sel_clr;
   logic mreset, clr_all;
   logic ctl_word_data_int_ff, nxt_data_int;

   function automatic logic [7:0] decode_clear(input iosi_ctl_type c, input logic stb);
      logic [7:0] d;
      d = 8'h00;
      if (stb)
      begin
         // clear-all and master reset override whatever selective code rides along
         if (c.ctl_clear_all_bit || c.ctl_master_reset_bit)
            d = 8'hFF;
         else
         begin
            case ({c.ctl_clear_sel_bit_a, c.ctl_clear_sel_bit_b, c.ctl_clear_sel_bit_c})
               CLR_PROG: d[IST_PROG] = 1'b1;
               CLR_TIME_XFER:
               begin
                  // the time-out source only clears while the start bit is written zero
                  if (!c.ctl_timer_start_bit)
                     d[IST_TIME_OUT] = 1'b1;
                  d[IST_XFER_ERR] = 1'b1;
               end
               CLR_CLEAR_IF: d[IST_CLEAR_IF] = 1'b1;
               CLR_DATA_XFER: d[IST_DATA_XFER] = 1'b1;
               CLR_DEV_A: d[IST_DEV_A] = 1'b1;
               CLR_DEV_B: d[IST_DEV_B] = 1'b1;
               CLR_DEV_C: d[IST_DEV_C] = 1'b1;
               default: d = 8'h00;
            endcase
         end
      end
      return d;
   endfunction : decode_clear

   // master reset comes from the system pin or control bit 0; it outranks every set except the zero_low_byte and device_end_to_channel pulses
   assign mreset = !master_clear_n || (ctl_strobe && ctl_word.ctl_master_reset_bit);
   // clear-all empties the sources but leaves the timer start flop alone
   assign clr_all = ctl_strobe && ctl_word.ctl_clear_all_bit;
   assign sel_clr = decode_clear(ctl_word, ctl_strobe);

   // pin order: 0 device end, 1 clear interface, 2..5 status 8..11
   always_comb
   begin
      nxt_sync1 = {dev_status_pin, clear_interface_pin, device_end_pin};
      nxt_sync2 = sync1_ff;
      nxt_sync3 = sync2_ff;
      nxt_pin = pin_ff;
      for (int i = 0; i < 6; i++)
         if (sync2_ff[i] == sync3_ff[i])
            nxt_pin[i] = sync3_ff[i];
   end

   // service requests and device end
   always_comb
   begin
      logic dev_end_edge;
      dev_end_edge = nxt_pin[0] && !pin_ff[0];
      nxt_cmd_rq = command_request_ff;
      nxt_xfer_rq = transfer_request_ff;
      nxt_data_rq = data_request_ff;
      nxt_eot_rq = end_of_transfer_request_ff;
      nxt_dev_end = dev_end_ff;
      nxt_zero = 1'b0;
      nxt_fwd_end = 1'b0;
      if (service_request_ack)
      begin
         nxt_cmd_rq = 1'b0;
         nxt_xfer_rq = 1'b0;
         nxt_data_rq = 1'b0;
         nxt_eot_rq = 1'b0;
         nxt_dev_end = 1'b0;
      end
      // sets come after the acknowledge, so a request raised in the ack cycle survives
      if (program_mode)
      begin
         if (cmd_done || (opt.opt_status11_request && pin_ff[5]))
            nxt_cmd_rq = 1'b1;
         if (data_in_ready)
            nxt_data_rq = 1'b1;
         if (data_out_ready)
            nxt_xfer_rq = 1'b1;
         if (xfer_finished)
            nxt_eot_rq = 1'b1;
         if (dev_end_edge)
         begin
            nxt_dev_end = 1'b1;
            nxt_data_rq = 1'b1;
            if (two_byte_xfer && seq_count == SEQ_COUNT_3)
               nxt_zero = 1'b1;
            nxt_fwd_end = more_data;
         end
      end
      if (mreset)
      begin
         nxt_cmd_rq = 1'b0;
         nxt_xfer_rq = 1'b0;
         nxt_data_rq = 1'b0;
         nxt_eot_rq = 1'b0;
         nxt_dev_end = 1'b0;
      end
   end

   // interrupt sources, timer and enable
   always_comb
   begin
      logic [7:0] set_src;
      set_src = 8'h00;
      nxt_seq_prev = seq_count;
      nxt_start = start_ff;
      nxt_timer = timer_ff;
      nxt_timed_out = timed_out_ff;
      nxt_ien = ien_ff;
      if (ctl_strobe)
      begin
         nxt_start = ctl_word.ctl_timer_start_bit;
         nxt_ien = ctl_word.ctl_interrupt_enable_bit;
      end
      // restart needs the start flop to fall first, so the timer re-arms only from idle
      if (!start_ff)
      begin
         nxt_timer = '0;
         nxt_timed_out = 1'b0;
      end
      else if (timer_ff < TW'(TIMER_COUNT - 1))
         nxt_timer = timer_ff + TW'(1);
      else
         nxt_timed_out = 1'b1;
      set_src[IST_TIME_OUT] = start_ff && !timed_out_ff && nxt_timed_out;
      set_src[IST_XFER_ERR] = channel_transfer_error;
      set_src[IST_PROG] = programmed_int_req;
      set_src[IST_CLEAR_IF] = nxt_pin[1] && !pin_ff[1];
      set_src[IST_DATA_XFER] = ctl_word_data_int_ff && seq_prev_ff == SEQ_COUNT_3
                               && seq_count == SEQ_COUNT_0;
      // device inputs with their option off never set a source
      set_src[IST_DEV_A] = opt.opt_dev_int_a && nxt_pin[2] && !pin_ff[2];
      set_src[IST_DEV_B] = opt.opt_dev_int_b && nxt_pin[3] && !pin_ff[3];
      set_src[IST_DEV_C] = opt.opt_dev_int_c && !nxt_pin[4] && pin_ff[4];
      // a set arriving with its clear is kept
      nxt_src = (src_ff & ~sel_clr) | set_src;
      if (mreset)
      begin
         nxt_src = IST_RESET;
         nxt_start = 1'b0;
         nxt_ien = 1'b0;
      end
      else if (clr_all)
         nxt_src = set_src;
      if (!interrupt_poll_accept_n)
         nxt_ien = 1'b0;
   end

   // control bit 11 is held until the next strobe or master reset, so transfers meanwhile raise the data interrupt
   always_comb
   begin
      nxt_data_int = ctl_word_data_int_ff;
      if (ctl_strobe)
         nxt_data_int = ctl_word.ctl_data_int_bit;
      if (mreset)
         nxt_data_int = 1'b0;
   end

   // clk_en low freezes every flop, synchroniser stages included
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         pin_ff <= '0;
         command_request_ff <= 1'b0;
         transfer_request_ff <= 1'b0;
         data_request_ff <= 1'b0;
         end_of_transfer_request_ff <= 1'b0;
         dev_end_ff <= 1'b0;
         zero_ff <= 1'b0;
         fwd_end_ff <= 1'b0;
         src_ff <= IST_RESET;
         start_ff <= 1'b0;
         ien_ff <= 1'b0;
         timed_out_ff <= 1'b0;
         timer_ff <= '0;
         seq_prev_ff <= SEQ_COUNT_0;
         ctl_word_data_int_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         sync3_ff <= nxt_sync3;
         pin_ff <= nxt_pin;
         command_request_ff <= nxt_cmd_rq;
         transfer_request_ff <= nxt_xfer_rq;
         data_request_ff <= nxt_data_rq;
         end_of_transfer_request_ff <= nxt_eot_rq;
         dev_end_ff <= nxt_dev_end;
         zero_ff <= nxt_zero;
         fwd_end_ff <= nxt_fwd_end;
         src_ff <= nxt_src;
         start_ff <= nxt_start;
         ien_ff <= nxt_ien;
         timed_out_ff <= nxt_timed_out;
         timer_ff <= nxt_timer;
         seq_prev_ff <= nxt_seq_prev;
         ctl_word_data_int_ff <= nxt_data_int;
      end
   end

   assign service_request_n = !(command_request_ff || transfer_request_ff
                              || data_request_ff || end_of_transfer_request_ff);
   assign device_command_inhibit = dev_end_ff;
   assign device_end_to_channel = fwd_end_ff;
   assign zero_low_byte = zero_ff;
   assign interrupt_status = src_ff;
   assign interrupt_pending = |src_ff;
   // interrupt_active is the command function's busy flag, so a second request waits
   assign interrupt_request = ien_ff && interrupt_pending && !interrupt_active;

endmodule : iosi_service_interrupt

//--- iosi_service_interrupt_monitor.sv
`timescale 1ns/1ps
module iosi_service_interrupt_monitor
   import iosi_pkg::*;
#(
   parameter longint unsigned TIMER_COUNT = 20
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // control and events
   input wire iosi_pkg::iosi_ctl_type ctl_word,
   input wire logic ctl_strobe,
   input wire logic program_mode,
   input wire logic cmd_done,
   input wire logic service_request_ack,
   input wire logic channel_transfer_error,
   input wire logic programmed_int_req,
   input wire logic interrupt_poll_accept_n,
   input wire logic interrupt_active,
   // outputs watched
   input wire logic service_request_n,
   input wire logic interrupt_pending,
   input wire logic interrupt_request,
   input wire logic [7:0] interrupt_status
);
   // slack past the walk so a one-cycle pipeline choice never fires this
   localparam int TO_LATE = 3;
   logic [31:0] tmr_cnt_ff, nxt_tmr_cnt;
   logic tmr_run_ff, nxt_tmr_run;

   always_comb
   begin
      nxt_tmr_run = tmr_run_ff;
      nxt_tmr_cnt = tmr_cnt_ff;
      if (ctl_strobe)
      begin
         nxt_tmr_run = ctl_word.ctl_timer_start_bit && !ctl_word.ctl_master_reset_bit
            && !ctl_word.ctl_clear_all_bit;
         nxt_tmr_cnt = 32'h0;
      end
      else if (tmr_run_ff && clk_en)
         nxt_tmr_cnt = tmr_cnt_ff + 32'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         tmr_run_ff <= 1'b0;
         tmr_cnt_ff <= 32'h0;
      end
      else
      begin
         tmr_run_ff <= nxt_tmr_run;
         tmr_cnt_ff <= nxt_tmr_cnt;
      end
   end

   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_cmd_set;
      program_mode && cmd_done && clk_en;
   endsequence
   sequence s_ack_idle;
      service_request_ack && !program_mode && clk_en;
   endsequence

   a_cmd_sets_req: assert property (s_cmd_set |=> !service_request_n)
      else $error("command request not raised");
   a_ack_clears_req: assert property (s_ack_idle |=> service_request_n)
      else $error("acknowledge left a request set");
   a_idle_no_req: assert property (!program_mode && service_request_n && clk_en
      |=> service_request_n)
      else $error("service request outside channel program");
   a_pending_is_or: assert property (interrupt_pending == (interrupt_status != 8'h00))
      else $error("pending does not follow status");
   a_req_gated: assert property (interrupt_request |-> interrupt_pending
      && !interrupt_active)
      else $error("request without pending or while active");
   a_poll_clears_en: assert property (!interrupt_poll_accept_n && !ctl_strobe && clk_en
      |=> !interrupt_request)
      else $error("poll accept left enable set");
   a_xfer_err_latch: assert property (channel_transfer_error && clk_en
      |=> interrupt_status[IST_XFER_ERR] [*2])
      else $error("transfer error not latched");
   a_prog_latch: assert property (programmed_int_req && clk_en
      |=> interrupt_status[IST_PROG])
      else $error("programmed interrupt not latched");
   a_clear_all_src: assert property (ctl_strobe && ctl_word.ctl_clear_all_bit
      && !channel_transfer_error && !programmed_int_req
      |=> !interrupt_status[IST_XFER_ERR] && !interrupt_status[IST_PROG])
      else $error("clear all left a source set");
   a_timer_expires: assert property (tmr_cnt_ff == TIMER_COUNT + TO_LATE
      |-> interrupt_status[IST_TIME_OUT])
      else $error("transfer timer did not time out");
endmodule : iosi_service_interrupt_monitor

bind iosi_service_interrupt iosi_service_interrupt_monitor #(.TIMER_COUNT(TIMER_COUNT)) u_mon (
   .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .ctl_word(ctl_word),
   .ctl_strobe(ctl_strobe), .program_mode(program_mode), .cmd_done(cmd_done),
   .service_request_ack(service_request_ack), .channel_transfer_error(channel_transfer_error),
   .programmed_int_req(programmed_int_req), .interrupt_poll_accept_n(interrupt_poll_accept_n),
   .interrupt_active(interrupt_active), .service_request_n(service_request_n),
   .interrupt_pending(interrupt_pending), .interrupt_request(interrupt_request),
   .interrupt_status(interrupt_status));

//--- iosi_channel_model.sv
`timescale 1ns/1ps
module iosi_channel_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // service handshake
   input wire logic service_request_n,
   input wire logic [3:0] ack_delay,
   output logic service_request_ack
);
   logic [3:0] wait_ff;

   // ack is a one-cycle pulse, dropped at the next edge whatever the request line does, so each request gets one answer
   always_ff @(posedge core_clk)
   begin
      if (rst || service_request_n)
      begin
         wait_ff <= 4'h0;
         service_request_ack <= 1'b0;
      end
      else if (service_request_ack)
      begin
         // one answer per request; a request raised at the acknowledge edge waits afresh
         wait_ff <= 4'h0;
         service_request_ack <= 1'b0;
      end
      else if (wait_ff == ack_delay)
         service_request_ack <= 1'b1;
      else
         wait_ff <= wait_ff + 4'h1;
   end
endmodule : iosi_channel_model

//--- test_iosi_service_interrupt.sv
`timescale 1ns/1ps
module test_iosi_service_interrupt;
   import iosi_pkg::*;
   localparam longint unsigned TCNT = 20;
   logic core_clk = 1'b0;
   logic rst, strobe, pmode, two_byte, more, cmd, din, dev_end, clr_if, ack, xerr, preq;
   logic poll_n, iact, srn, de_chan, inhibit, zlb, pend, ireq, cen, dout, xfin, mclr_n;
   logic [1:0] seq;
   logic [3:0] dstat, ack_delay;
   logic [7:0] ist;
   iosi_ctl_type ctl_word;
   iosi_opt_type opt;
   int error_cnt, tests_run, cyc;

   iosi_service_interrupt #(.TIMER_COUNT(TCNT)) dut (
      .core_clk(core_clk), .rst(rst), .clk_en(cen), .ctl_strobe(strobe), .ctl_word(ctl_word),
      .opt(opt), .program_mode(pmode), .seq_count(seq), .two_byte_xfer(two_byte),
      .more_data(more), .cmd_done(cmd), .data_in_ready(din), .data_out_ready(dout),
      .xfer_finished(xfin), .device_end_pin(dev_end), .clear_interface_pin(clr_if),
      .dev_status_pin(dstat), .service_request_ack(ack), .channel_transfer_error(xerr),
      .programmed_int_req(preq), .interrupt_poll_accept_n(poll_n), .master_clear_n(mclr_n),
      .interrupt_active(iact), .service_request_n(srn), .device_end_to_channel(de_chan),
      .device_command_inhibit(inhibit), .zero_low_byte(zlb), .interrupt_pending(pend),
      .interrupt_request(ireq), .interrupt_status(ist));
   iosi_channel_model u_chan (.core_clk(core_clk), .rst(rst), .service_request_n(srn),
      .ack_delay(ack_delay), .service_request_ack(ack));

   initial
   begin
      forever #2 core_clk = ~core_clk;
   end

   task wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wt

   task chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chk

   task ctl(input iosi_ctl_type w);
      ctl_word = w;
      strobe = 1'b1;
      wt(1);
      strobe = 1'b0;
      wt(1);
   endtask : ctl

   task wait_srn;
      for (int i = 0; i < 20 && srn !== 1'b1; i++) wt(1);
      chk(srn === 1'b1, "request not acknowledged");
   endtask : wait_srn

   task t_service;
      cmd = 1'b1;
      wt(1);
      chk(srn === 1'b1, "request outside program");
      pmode = 1'b1;
      wt(1);
      cmd = 1'b0;
      chk(srn === 1'b0, "command request");
      wait_srn();
      // slow channel; program ends before the ack arrives
      ack_delay = 4'h6;
      din = 1'b1;
      wt(1);
      din = 1'b0;
      pmode = 1'b0;
      chk(srn === 1'b0, "data request");
      wait_srn();
      pmode = 1'b1;
      dstat[3] = 1'b1;
      wt(6);
      chk(srn === 1'b1, "bit 11 without option");
      opt.opt_status11_request = 1'b1;
      wt(6);
      chk(srn === 1'b0, "bit 11 request");
      dstat[3] = 1'b0;
      wt(6);
      wait_srn();
   endtask : t_service

   task t_dev_end(input logic m);
      logic z, d, s, i;
      {z, d, s, i} = 4'h0;
      more = m;
      dev_end = 1'b1;
      repeat (8)
      begin
         wt(1);
         {z, d, s, i} = {z | zlb, d | de_chan, s | ~srn, i | inhibit};
      end
      chk(z === (two_byte && seq == 2'h3), "low byte zeroing");
      chk(s === 1'b1 && i === 1'b1, "second byte end");
      chk(d === m, "device end forwarding");
      dev_end = 1'b0;
      wait_srn();
   endtask : t_dev_end

   task t_sources;
      logic [2:0] code [4];
      logic [7:0] left [4];
      code = '{3'h3, 3'h2, 3'h0, 3'h1};
      left = '{8'h70, 8'h60, 8'h40, 8'h00};
      ctl(8'h04);
      {seq, xerr, preq, clr_if} = 5'h07;
      wt(1);
      {xerr, preq} = 2'h0;
      wt(5);
      clr_if = 1'b0;
      chk(ist === 8'h78 && pend === 1'b1, "sources latched");
      for (int i = 0; i < 4; i++)
      begin
         ctl({2'b00, code[i], 3'b000});
         chk(ist === left[i], "selective clear");
      end
      chk(pend === 1'b0, "pending after clears");
   endtask : t_sources

   task t_devint;
      dstat[2:0] = 3'h7;
      wt(6);
      dstat[2:0] = 3'h0;
      wt(6);
      chk(ist === 8'h00, "disabled device inputs");
      {opt.opt_dev_int_a, opt.opt_dev_int_b, opt.opt_dev_int_c} = 3'h7;
      dstat[2:0] = 3'h7;
      wt(6);
      chk(ist === 8'h03, "leading edges");
      dstat[2:0] = 3'h0;
      wt(6);
      chk(ist === 8'h07, "trailing edge");
      ctl(8'h40);
      chk(ist === 8'h00 && pend === 1'b0, "clear all");
   endtask : t_devint

   task t_timer;
      ctl(8'h01);
      wt(TCNT + 6);
      chk(ist === 8'h80 && pend === 1'b1, "time out");
      ctl(8'h08);
      chk(ist === 8'h00, "timer clear");
      ctl(8'h01);
      wt(TCNT + 6);
      ctl(8'h03);
      chk(ireq === 1'b1, "enabled request");
      iact = 1'b1;
      wt(1);
      chk(ireq === 1'b0, "request blocked while active");
      iact = 1'b0;
      poll_n = 1'b0;
      wt(1);
      poll_n = 1'b1;
      chk(ireq === 1'b0, "poll accept");
      ctl(8'h80);
      chk(ist === 8'h00 && pend === 1'b0, "master reset");
   endtask : t_timer

   task t_misc;
      dout = 1'b1;
      wt(1);
      dout = 1'b0;
      chk(srn === 1'b0, "transfer request");
      wait_srn();
      xfin = 1'b1;
      wt(1);
      xfin = 1'b0;
      chk(srn === 1'b0, "end of transfer request");
      wait_srn();
      // clock enable low: the programmed request must not be taken
      cen = 1'b0;
      preq = 1'b1;
      wt(2);
      preq = 1'b0;
      cen = 1'b1;
      chk(ist === 8'h00, "clock enable freeze");
      xerr = 1'b1;
      wt(1);
      xerr = 1'b0;
      chk(ist === 8'h40, "error latched after freeze");
      wt(1);
      mclr_n = 1'b0;
      wt(1);
      mclr_n = 1'b1;
      chk(ist === 8'h00 && pend === 1'b0, "system master reset");
   endtask : t_misc

   task results;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      {strobe, pmode, two_byte, more, cmd, din, dev_end, clr_if, xerr, preq, iact} = '0;
      {dout, xfin} = 2'h0;
      {poll_n, cen, mclr_n, seq, dstat, ack_delay, ctl_word, opt} =
         {3'h7, 2'h0, 4'h0, 4'h1, 8'h00, 4'h0};
      {error_cnt, tests_run, cyc} = '0;
      rst = 1'b1;
      wt(5);
      rst = 1'b0;
      wt(1);
      chk(srn === 1'b1 && ist === IST_RESET && ireq === 1'b0, "reset values");
      t_service();
      {two_byte, seq} = 3'h7;
      t_dev_end(1'b0);
      two_byte = 1'b0;
      t_dev_end(1'b1);
      t_sources();
      t_devint();
      t_timer();
      t_misc();
      results();
   end
endmodule : test_iosi_service_interrupt
